// ===== src/adcst_defines.svh
// register map, field layout, reset values and sample durations
`ifndef ADCST_DEFINES_SVH
`define ADCST_DEFINES_SVH

// byte offsets of the registers
`define ADCST_OFS_SAMPLE_UPPER  8'h0C
`define ADCST_OFS_SAMPLE_LOWER  8'h10
`define ADCST_OFS_WDG_UPPER     8'h24
`define ADCST_OFS_WDG_LOWER     8'h28
`define ADCST_OFS_IRQ_STATUS    8'h40
`define ADCST_OFS_IRQ_ENABLE    8'h44
`define ADCST_OFS_IRQ_CLEAR     8'h48

// writable bits of each register
`define ADCST_MASK_SAMPLE_UPPER 32'h00FF_FFFF
`define ADCST_MASK_SAMPLE_LOWER 32'h3FFF_FFFF
`define ADCST_MASK_LIMIT        32'h0000_0FFF
`define ADCST_MASK_IRQ          32'h0000_0003

// reset values
`define ADCST_RST_SAMPLE        32'h0000_0000
`define ADCST_RST_WDG_UPPER     32'h0000_0FFF
`define ADCST_RST_WDG_LOWER     32'h0000_0000
`define ADCST_RST_IRQ           32'h0000_0000

// channel layout
`define ADCST_CHANNELS          18
`define ADCST_UPPER_FIRST_CHAN  10
`define ADCST_CODE_W            3

// status bit positions
`define ADCST_BIT_ABOVE         0
`define ADCST_BIT_BELOW         1

// sample durations, in halves of a converter clock cycle
`define ADCST_HALF_CODE0        10'h005
`define ADCST_HALF_CODE1        10'h01D
`define ADCST_HALF_CODE2        10'h037
`define ADCST_HALF_CODE3        10'h06F
`define ADCST_HALF_CODE4        10'h0A7
`define ADCST_HALF_CODE5        10'h0DF
`define ADCST_HALF_CODE6        10'h11F
`define ADCST_HALF_CODE7        10'h3BF

`endif

// ===== src/adcst_pkg.sv
// types shared by the sample-time and watchdog configuration block
`default_nettype none
package adcst_pkg;

   typedef logic [2:0]  adcst_code_t;
   typedef logic [11:0] adcst_limit_t;
   typedef logic [9:0]  adcst_half_t;

   typedef enum logic [1:0] {
      ADCST_IDLE = 2'b01,
      ADCST_RESP = 2'b10
   } adcst_bus_state_t;

endpackage
`default_nettype wire

// ===== src/adcst_decode.sv
// sampling-time code to sample duration in half converter cycles
`include "adcst_defines.svh"
`default_nettype none
module adcst_decode
   import adcst_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // code in, duration out
   input  wire adcst_code_t code,
   output var  adcst_half_t half_cycles
);

   adcst_half_t next_half_cycles;

   always_comb begin
      case (code)
         3'b000:  next_half_cycles = `ADCST_HALF_CODE0;
         3'b001:  next_half_cycles = `ADCST_HALF_CODE1;
         3'b010:  next_half_cycles = `ADCST_HALF_CODE2;
         3'b011:  next_half_cycles = `ADCST_HALF_CODE3;
         3'b100:  next_half_cycles = `ADCST_HALF_CODE4;
         3'b101:  next_half_cycles = `ADCST_HALF_CODE5;
         3'b110:  next_half_cycles = `ADCST_HALF_CODE6;
         3'b111:  next_half_cycles = `ADCST_HALF_CODE7;
         default: next_half_cycles = `ADCST_HALF_CODE0;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         half_cycles <= `ADCST_HALF_CODE0;
      end else begin
         half_cycles <= next_half_cycles;
      end
   end

endmodule // adcst_decode
`default_nettype wire

// ===== src/adcst_wdg.sv
// window comparator for watchdog 0, one-cycle event pulses
`default_nettype none
module adcst_wdg
   import adcst_pkg::*;
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // converted result
   input  wire logic         valid,
   input  wire adcst_limit_t data,
   // window bounds
   input  wire adcst_limit_t upper,
   input  wire adcst_limit_t lower,
   // events
   output logic              above,
   output logic              below
);

   wire next_above = valid && (data > upper);
   wire next_below = valid && (data < lower);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         above <= 1'b0;
         below <= 1'b0;
      end else begin
         above <= next_above;
         below <= next_below;
      end
   end

endmodule // adcst_wdg
`default_nettype wire

// ===== src/adcst_top.sv
// converter sample-time and watchdog-0 configuration, APB slave
//
// How it works
// - each 3-bit code maps to 2.5 up to 479.5 converter cycles
// - upper register holds channels 10..17, three bits each, from bit 0
// - lower register holds channels 0..9, three bits each, from bit 0
// - watchdog 0 upper bound is a 12-bit writable field, bits 11:0
// - upper bound resets to all ones in its 12-bit field
// - both sample-time registers reset to zero
// - a 12-bit writable lower bound sits beside the upper bound
//
// The APB register port was left to the implementer.
`include "adcst_defines.svh"
`default_nettype none
module adcst_top
   import adcst_pkg::*;
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RESET,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic             PREADY,
   output logic [31:0]      PRDATA,
   output logic             PSLVERR,
   // converted results
   input  wire logic        RESULT_VALID,
   input  wire logic [11:0] RESULT_DATA,
   // sample duration query
   input  wire logic [4:0]  SAMPLE_CHANNEL,
   output logic [2:0]       SAMPLE_CODE,
   output logic [9:0]       SAMPLE_HALF_CYCLES,
   // configuration seen by the converter
   output logic [53:0]      CHAN_SAMPLE_CODES,
   output logic [11:0]      WATCHDOG0_UPPER,
   output logic [11:0]      WATCHDOG0_LOWER,
   // events
   output logic             WDG_EVENT,
   output logic             IRQ
);

   ////////////////////////////////////////////////////////////////////////
   // register state

   logic [31:0]      sample_upper;
   logic [31:0]      sample_lower;
   logic [31:0]      wdg_upper;
   logic [31:0]      wdg_lower;
   logic [1:0]       irq_status;
   logic [1:0]       irq_enable;
   adcst_bus_state_t bus_state;
   adcst_bus_state_t next_bus_state;

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   wire access_phase = PSEL && PENABLE;
   wire completing   = access_phase && PREADY;
   wire word_aligned = (PADDR[1:0] == 2'b00);
   wire full_word    = (PSTRB == 4'hF);

   wire hit_sample_upper = (PADDR == `ADCST_OFS_SAMPLE_UPPER);
   wire hit_sample_lower = (PADDR == `ADCST_OFS_SAMPLE_LOWER);
   wire hit_wdg_upper    = (PADDR == `ADCST_OFS_WDG_UPPER);
   wire hit_wdg_lower    = (PADDR == `ADCST_OFS_WDG_LOWER);
   wire hit_irq_status   = (PADDR == `ADCST_OFS_IRQ_STATUS);
   wire hit_irq_enable   = (PADDR == `ADCST_OFS_IRQ_ENABLE);
   wire hit_irq_clear    = (PADDR == `ADCST_OFS_IRQ_CLEAR);

   wire hit_any = hit_sample_upper || hit_sample_lower ||
                  hit_wdg_upper || hit_wdg_lower ||
                  hit_irq_status || hit_irq_enable || hit_irq_clear;

   // narrow writes are refused whole rather than merged by lane:
   // partial writes would leave a limit half old, half new
   wire bad_write = PWRITE && !full_word;
   wire bad_addr  = !word_aligned || !hit_any;
   wire refused   = bad_addr || bad_write;

   wire wr_ok = completing && PWRITE && !refused;

   wire wr_sample_upper = wr_ok && hit_sample_upper;
   wire wr_sample_lower = wr_ok && hit_sample_lower;
   wire wr_wdg_upper    = wr_ok && hit_wdg_upper;
   wire wr_wdg_lower    = wr_ok && hit_wdg_lower;
   wire wr_irq_enable   = wr_ok && hit_irq_enable;
   wire wr_irq_clear    = wr_ok && hit_irq_clear;

   ////////////////////////////////////////////////////////////////////////
   // next register values; unused bits forced to their reset value

   wire [31:0] next_sample_upper =
      PWDATA & `ADCST_MASK_SAMPLE_UPPER;
   wire [31:0] next_sample_lower =
      PWDATA & `ADCST_MASK_SAMPLE_LOWER;
   wire [31:0] next_wdg_upper =
      PWDATA & `ADCST_MASK_LIMIT;
   wire [31:0] next_wdg_lower =
      PWDATA & `ADCST_MASK_LIMIT;
   wire [1:0]  next_irq_enable =
      PWDATA[1:0];

   ////////////////////////////////////////////////////////////////////////
   // read mux; clear register reads as zero

   wire [31:0] irq_status_word = {30'h0000_0000, irq_status};
   wire [31:0] irq_enable_word = {30'h0000_0000, irq_enable};

   wire [31:0] read_word =
      hit_sample_upper ? sample_upper    :
      hit_sample_lower ? sample_lower    :
      hit_wdg_upper    ? wdg_upper       :
      hit_wdg_lower    ? wdg_lower       :
      hit_irq_status   ? irq_status_word :
      hit_irq_enable   ? irq_enable_word :
                         32'h0000_0000;

   wire [31:0] next_prdata =
      (!PWRITE && !refused) ? read_word : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // bus handshake: one wait state, answer registered

   wire start_answer = access_phase && !PREADY &&
                       (bus_state == ADCST_IDLE);

   always_comb begin
      case (bus_state)
         ADCST_IDLE: begin
            next_bus_state = start_answer ? ADCST_RESP : ADCST_IDLE;
         end
         ADCST_RESP: begin
            next_bus_state = ADCST_IDLE;
         end
         default: begin
            next_bus_state = ADCST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         bus_state <= ADCST_IDLE;
      end else begin
         bus_state <= next_bus_state;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         PREADY <= 1'b0;
      end else begin
         PREADY <= start_answer;
      end
   end

   // read data is zero outside the answer cycle
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         PRDATA <= 32'h0000_0000;
      end else if (start_answer) begin
         PRDATA <= next_prdata;
      end else begin
         PRDATA <= 32'h0000_0000;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         PSLVERR <= 1'b0;
      end else begin
         PSLVERR <= start_answer && refused;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         sample_upper <= `ADCST_RST_SAMPLE;
      end else if (wr_sample_upper) begin
         sample_upper <= next_sample_upper;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         sample_lower <= `ADCST_RST_SAMPLE;
      end else if (wr_sample_lower) begin
         sample_lower <= next_sample_lower;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         wdg_upper <= `ADCST_RST_WDG_UPPER;
      end else if (wr_wdg_upper) begin
         wdg_upper <= next_wdg_upper;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         wdg_lower <= `ADCST_RST_WDG_LOWER;
      end else if (wr_wdg_lower) begin
         wdg_lower <= next_wdg_lower;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-channel codes gathered into one flat vector, channel 0 lowest

   wire [53:0] all_codes;

   genvar ch;
   generate
      for (ch = 0; ch < `ADCST_CHANNELS; ch = ch + 1) begin : g_chan
         if (ch < `ADCST_UPPER_FIRST_CHAN) begin : g_low
            assign all_codes[3*ch +: 3] =
               sample_lower[3*ch +: 3];
         end else begin : g_high
            assign all_codes[3*ch +: 3] =
               sample_upper[3*(ch-`ADCST_UPPER_FIRST_CHAN) +: 3];
         end
      end
   endgenerate

   // channels past the last one read the shortest code
   wire         chan_valid = (SAMPLE_CHANNEL < 5'd18);
   wire [2:0]   chan_code  = all_codes[3*SAMPLE_CHANNEL +: 3];
   adcst_code_t query_code;
   assign query_code = chan_valid ? chan_code : 3'h0;

   adcst_decode u_decode (
      .clk         (CLK),
      .reset       (RESET),
      .code        (query_code),
      .half_cycles (SAMPLE_HALF_CYCLES)
   );

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         SAMPLE_CODE <= 3'h0;
      end else begin
         SAMPLE_CODE <= query_code;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         CHAN_SAMPLE_CODES <= 54'h0;
      end else begin
         CHAN_SAMPLE_CODES <= all_codes;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         WATCHDOG0_UPPER <= 12'hFFF;
      end else begin
         WATCHDOG0_UPPER <= wdg_upper[11:0];
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         WATCHDOG0_LOWER <= 12'h000;
      end else begin
         WATCHDOG0_LOWER <= wdg_lower[11:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // watchdog 0 comparison against the live register values

   logic above;
   logic below;

   adcst_wdg u_wdg (
      .clk   (CLK),
      .reset (RESET),
      .valid (RESULT_VALID),
      .data  (RESULT_DATA),
      .upper (wdg_upper[11:0]),
      .lower (wdg_lower[11:0]),
      .above (above),
      .below (below)
   );

   ////////////////////////////////////////////////////////////////////////
   // sticky status; a new event wins over a clear in the same cycle

   wire [1:0] event_bits = {below, above};
   wire [1:0] clear_bits = wr_irq_clear ? PWDATA[1:0] : 2'b00;
   wire [1:0] next_irq_status =
      (irq_status & ~clear_bits) | event_bits;

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         irq_status <= 2'b00;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         irq_enable <= 2'b00;
      end else begin
         if (wr_irq_enable) begin
            irq_enable <= next_irq_enable;
         end
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         WDG_EVENT <= 1'b0;
      end else begin
         WDG_EVENT <= above || below;
      end
   end

   // interrupt follows status and enable one cycle late
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_status & irq_enable);
      end
   end

endmodule // adcst_top
`default_nettype wire

// ===== dv/adcst_top_properties.sv
// port-level checks of the sample-time and watchdog block
`default_nettype none
module adcst_props (
   // clock and reset
   input wire logic        CLK,
   input wire logic        RESET,
   // apb
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0]  PSTRB,
   input wire logic        PREADY,
   input wire logic [31:0] PRDATA,
   input wire logic        PSLVERR,
   // results and configuration
   input wire logic        RESULT_VALID,
   input wire logic [11:0] RESULT_DATA,
   input wire logic [4:0]  SAMPLE_CHANNEL,
   input wire logic [2:0]  SAMPLE_CODE,
   input wire logic [9:0]  SAMPLE_HALF_CYCLES,
   input wire logic [53:0] CHAN_SAMPLE_CODES,
   input wire logic [11:0] WATCHDOG0_UPPER,
   input wire logic [11:0] WATCHDOG0_LOWER,
   input wire logic        WDG_EVENT
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] HALF [8] = '{10'h005, 10'h01D, 10'h037,
      10'h06F, 10'h0A7, 10'h0DF, 10'h11F, 10'h3BF};
   logic [2:0] sel;
   // widened so channel 17 does not wrap the index
   assign sel = CHAN_SAMPLE_CODES[7'(SAMPLE_CHANNEL) * 7'd3 +: 3];
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence setup_access;
      PSEL && !PENABLE ##1 PSEL && PENABLE;
   endsequence
   sequence outside;
      RESULT_VALID && (RESULT_DATA > WATCHDOG0_UPPER ||
                       RESULT_DATA < WATCHDOG0_LOWER);
   endsequence
   sequence upper_write;
      PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h24 && !PSLVERR;
   endsequence
   sequence lower_write;
      PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h28 && !PSLVERR;
   endsequence
   chk_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   chk_ready_wait: assert property (setup_access |=> PREADY)
      else $error("ready not after one wait");
   chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
      else $error("read data outside answer");
   chk_strobe_err: assert property
      (PREADY && PWRITE && PSTRB != 4'hF |-> PSLVERR)
      else $error("narrow write accepted");
   chk_half_decode: assert property
      (SAMPLE_HALF_CYCLES == HALF[SAMPLE_CODE])
      else $error("duration decode wrong");
   chk_code_query: assert property
      (SAMPLE_CHANNEL < 5'd18 ##1 $stable(CHAN_SAMPLE_CODES)
       |-> SAMPLE_CODE == $past(sel))
      else $error("queried code wrong");
   chk_upper_copy: assert property
      (upper_write |-> ##2 WATCHDOG0_UPPER == 12'($past(PWDATA, 2)))
      else $error("upper limit not stored");
   chk_lower_copy: assert property
      (lower_write |-> ##2 WATCHDOG0_LOWER == 12'($past(PWDATA, 2)))
      else $error("lower limit not stored");
   chk_event_raise: assert property (outside |-> ##2 WDG_EVENT)
      else $error("event missing");
   chk_event_cause: assert property
      (WDG_EVENT |-> $past(RESULT_VALID, 2))
      else $error("event without result");
endmodule // adcst_props
bind adcst_top adcst_props adcst_props_i (.CLK, .RESET, .PSEL, .PENABLE,
   .PWRITE, .PADDR, .PWDATA, .PSTRB, .PREADY, .PRDATA, .PSLVERR,
   .RESULT_VALID, .RESULT_DATA, .SAMPLE_CHANNEL, .SAMPLE_CODE,
   .SAMPLE_HALF_CYCLES, .CHAN_SAMPLE_CODES, .WATCHDOG0_UPPER,
   .WATCHDOG0_LOWER, .WDG_EVENT);
`default_nettype wire

// ===== dv/adc_sample_time_and_watchdog_cfg_bench.sv
// self-checking bench of the sample-time and watchdog block
`default_nettype none
module adc_sample_time_and_watchdog_cfg_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLK, RESET, PSEL, PENABLE, PWRITE, RESULT_VALID;
   logic        PREADY, PSLVERR, IRQ, WDG_EVENT, er;
   logic [7:0]  PADDR;
   logic [31:0] PWDATA, PRDATA, rd, seed;
   logic [3:0]  PSTRB;
   logic [11:0] RESULT_DATA, WATCHDOG0_UPPER, WATCHDOG0_LOWER;
   logic [4:0]  SAMPLE_CHANNEL;
   logic [2:0]  SAMPLE_CODE, e;
   logic [9:0]  SAMPLE_HALF_CYCLES;
   logic [53:0] CHAN_SAMPLE_CODES;
   logic [31:0] mdl [logic [7:0]];
   int          error_cnt, num_checks, cyc;
   localparam logic [9:0] HALF [8] = '{10'h005, 10'h01D, 10'h037,
      10'h06F, 10'h0A7, 10'h0DF, 10'h11F, 10'h3BF};
   localparam logic [7:0] ADR [4] = '{8'h0C, 8'h10, 8'h24, 8'h28};
   adcst_top adcst_top_i (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR,
      .PWDATA, .PSTRB, .PREADY, .PRDATA, .PSLVERR, .RESULT_VALID,
      .RESULT_DATA, .SAMPLE_CHANNEL, .SAMPLE_CODE, .SAMPLE_HALF_CYCLES,
      .CHAN_SAMPLE_CODES, .WATCHDOG0_UPPER, .WATCHDOG0_LOWER,
      .WDG_EVENT, .IRQ);
   always #2 CLK = ~CLK;
   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] msk(input logic [7:0] a);
      case (a)
         8'h0C: return 32'h00FF_FFFF;
         8'h10: return 32'h3FFF_FFFF;
         8'h24, 8'h28: return 32'h0000_0FFF;
         8'h44: return 32'h0000_0003;
         default: return 32'h0000_0000;
      endcase
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         error_cnt++;
      end
   endtask
   // holds the request until ready is sampled high at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      PSTRB <= s;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1) @(posedge CLK);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
      if (mdl.exists(a)) mdl[a] = d & msk(a);
      chk({31'h0, er}, {31'h0, !mdl.exists(a)});
   endtask
   task automatic rdc(input logic [7:0] a);
      apb(1'b0, a, seed, 4'hF);
      chk(rd, mdl.exists(a) ? mdl[a] : 32'h0);
      chk({31'h0, er}, {31'h0, !mdl.exists(a)});
   endtask
   // counts event pulses, then reads the sticky status
   task automatic res(input logic [11:0] d, input logic ev,
                      input logic [1:0] st);
      int n;
      n = 0;
      RESULT_VALID <= 1'b1;
      RESULT_DATA <= d;
      @(posedge CLK);
      RESULT_VALID <= 1'b0;
      RESULT_DATA <= ~d;
      repeat (5) begin
         @(posedge CLK);
         n += (WDG_EVENT === 1'b1);
      end
      chk(32'(n), {31'h0, ev});
      apb(1'b0, 8'h40, 32'h0, 4'hF);
      chk(rd, {30'h0, st});
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         test_done;
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      CLK = 1'b0;
      RESET = 1'b1;
      {PSEL, PENABLE, PWRITE, RESULT_VALID} = 4'h0;
      PADDR = 8'h00;
      PWDATA = 32'h0;
      PSTRB = 4'hF;
      RESULT_DATA = 12'h000;
      SAMPLE_CHANNEL = 5'h00;
      seed = 32'h0000_3151;
      mdl[8'h0C] = 32'h0;
      mdl[8'h10] = 32'h0;
      mdl[8'h24] = 32'h0000_0FFF;
      mdl[8'h28] = 32'h0;
      mdl[8'h44] = 32'h0;
      mdl[8'h48] = 32'h0;
      repeat (2) @(posedge CLK);
      RESET <= 1'b0;
      foreach (mdl[a]) rdc(a);
      $display("reset test done");
      repeat (16) begin
         seed = lfsr(seed);
         wr(ADR[seed[1:0]], lfsr(seed));
         rdc(ADR[seed[1:0]]);
      end
      $display("random write test done");
      // every code once in the upper channels, reserved bits set
      wr(8'h0C, 32'hFFFA_C688);
      for (int c = 0; c < 18; c++) begin
         SAMPLE_CHANNEL <= 5'(c);
         repeat (2) @(posedge CLK);
         e = 3'(c < 10 ? mdl[8'h10] >> (3 * c) : mdl[8'h0C] >> (3 * c - 30));
         chk({29'h0, SAMPLE_CODE}, {29'h0, e});
         chk({22'h0, SAMPLE_HALF_CYCLES}, {22'h0, HALF[e]});
         chk({29'h0, CHAN_SAMPLE_CODES[3 * c +: 3]}, {29'h0, e});
      end
      SAMPLE_CHANNEL <= 5'd25;
      repeat (2) @(posedge CLK);
      chk({29'h0, SAMPLE_CODE}, 32'h0);
      chk({22'h0, SAMPLE_HALF_CYCLES}, {22'h0, HALF[0]});
      $display("channel code test done");
      apb(1'b1, 8'h24, 32'h0000_0123, 4'h3);
      chk({31'h0, er}, 32'h1);
      rdc(8'h24);
      rdc(8'h30);
      rdc(8'h0D);
      chk({20'h0, WATCHDOG0_UPPER}, mdl[8'h24]);
      chk({20'h0, WATCHDOG0_LOWER}, mdl[8'h28]);
      $display("refusal test done");
      wr(8'h24, 32'h0000_0800);
      wr(8'h28, 32'h0000_0100);
      wr(8'h44, 32'h0000_0003);
      res(12'h900, 1'b1, 2'b01);
      chk({31'h0, IRQ}, 32'h1);
      wr(8'h48, 32'h0000_0001);
      res(12'h800, 1'b0, 2'b00);
      chk({31'h0, IRQ}, 32'h0);
      wr(8'h44, 32'h0000_0000);
      res(12'h0FF, 1'b1, 2'b10);
      res(12'h100, 1'b0, 2'b10);
      chk({31'h0, IRQ}, 32'h0);
      wr(8'h44, 32'h0000_0002);
      repeat (2) @(posedge CLK);
      chk({31'h0, IRQ}, 32'h1);
      $display("watchdog test done");
      test_done;
   end
endmodule // adc_sample_time_and_watchdog_cfg_bench
`default_nettype wire
